// ==== verilog/amt_top.sv ====
// Purpose: input-mode and data-format control for 16 converter channels, plus
//          the trigger compare register of the PWM time base
// Assumes: classic Wishbone slave, 50 MHz i_clk, asynchronous active-low reset
// Notes:   a conversion takes the mode of its channel when it starts
//          a start while busy is dropped silently, so software polls busy first
//          a mode write in the start cycle is not seen; write the mode, then start
//
// How it works
// - a channel whose input-mode bit is 1 converts differential, else single-ended.
// - a channel whose data-format bit is 1 gives signed data, else unsigned.
// - the low mode register holds channels 0..7, mode at bit 2n+1 and format at bit 2n.
// - the high mode register holds channels 8..15 in the same pattern.
// - a 13-bit compare value in bits 15:3 triggers the converter on a local time base match.
// - bits 2:0 of the trigger compare register ignore writes and read as zero.
//
// The register addresses and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/100ps
module amt_top (
  // clock and reset
  input  wire logic                           i_clk,
  input  wire logic                           i_rstn,
  // wishbone slave
  input  wire logic                           i_wb_cyc,
  input  wire logic                           i_wb_stb,
  input  wire logic                           i_wb_we,
  input  wire logic [3:0]                     i_wb_adr,
  input  wire logic [3:0]                     i_wb_sel,
  input  wire logic [31:0]                    i_wb_dat,
  output logic [31:0]                         o_wb_dat,
  output logic                                o_wb_ack,
  // pwm time base
  input  wire logic [amt_pkg::TRIG_W-1:0]     i_timebase,
  // converter control
  output logic                                o_conv_start,
  output logic [amt_pkg::CH_W-1:0]            o_conv_ch,
  output logic                                o_conv_channel_pair_input_mode,
  output logic                                o_conv_signed,
  input  wire logic                           i_conv_done
);
  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [15:0]                   mode_low;
  logic [15:0]                   mode_high;
  logic [amt_pkg::TRIG_W-1:0]    trigger_compare_value;
  logic [amt_pkg::CH_W-1:0]      ch_sel;
  logic                          local_tb_en;
  logic                          busy;
  logic                          trig_pulse;

  // channel n lookup across both mode registers
  function automatic logic [1:0] ch_pair(input logic [31:0] modes, input logic [3:0] ch);
    ch_pair = modes[{ch, 1'b0} +: 2];
  endfunction : ch_pair

  ////////////////////////////////////////////////////////////////////////////
  // bus decode
  wire        req        = i_wb_cyc && i_wb_stb && !o_wb_ack;
  wire        wr         = req && i_wb_we;
  wire        sel_lo     = i_wb_sel[0];
  wire        sel_hi     = i_wb_sel[1];
  wire        hit_trig   = (i_wb_adr == amt_pkg::OFS_TRIG);
  wire        hit_low    = (i_wb_adr == amt_pkg::OFS_MODE_LOW);
  wire        hit_high   = (i_wb_adr == amt_pkg::OFS_MODE_HIGH);
  wire        hit_ctrl   = (i_wb_adr == amt_pkg::OFS_CONV_CTRL);
  wire [15:0] trig_rd    = {trigger_compare_value, amt_pkg::TRIG_LOW_MASK};
  wire [31:0] all_modes  = {mode_high, mode_low};
  wire [1:0]  cur_pair   = ch_pair(all_modes, ch_sel);
  wire [15:0] ctrl_rd    = {5'h00, cur_pair[0], cur_pair[1], busy, 2'h0, local_tb_en, 1'b0, ch_sel};
  wire [15:0] rd_mux     = hit_trig ? trig_rd :
                           hit_low  ? mode_low :
                           hit_high ? mode_high :
                           hit_ctrl ? ctrl_rd : 16'h0000;
  wire        sw_start   = wr && hit_ctrl && sel_lo && i_wb_dat[amt_pkg::CC_START_BIT];
  wire        start_req  = (sw_start || trig_pulse) && !busy;
  wire [amt_pkg::CH_W-1:0] next_ch = (wr && hit_ctrl && sel_lo) ?
                           i_wb_dat[amt_pkg::CC_CH_LSB +: amt_pkg::CH_W] : ch_sel;
  wire [1:0]  start_pair = ch_pair(all_modes, next_ch);

  ////////////////////////////////////////////////////////////////////////////
  // bus answer, one cycle after the request
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
    end else begin
      o_wb_ack <= req;
      o_wb_dat <= req ? {16'h0000, rd_mux} : 32'h0000_0000;
    end
  end

  // mode registers, byte lanes 0 and 1
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      mode_low  <= amt_pkg::RST_MODE;
      mode_high <= amt_pkg::RST_MODE;
    end else begin
      if (wr && hit_low && sel_lo) mode_low[7:0]   <= i_wb_dat[7:0];
      if (wr && hit_low && sel_hi) mode_low[15:8]  <= i_wb_dat[15:8];
      if (wr && hit_high && sel_lo) mode_high[7:0]  <= i_wb_dat[7:0];
      if (wr && hit_high && sel_hi) mode_high[15:8] <= i_wb_dat[15:8];
    end
  end

  // trigger compare, low bits never stored
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      trigger_compare_value <= amt_pkg::RST_TRIG[15:3];
    end else begin
      if (wr && hit_trig && sel_lo) trigger_compare_value[4:0]  <= i_wb_dat[7:3];
      if (wr && hit_trig && sel_hi) trigger_compare_value[12:5] <= i_wb_dat[15:8];
    end
  end

  // control fields
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ch_sel      <= '0;
      local_tb_en <= 1'b0;
    end else begin
      ch_sel <= next_ch;
      if (wr && hit_ctrl && sel_lo) local_tb_en <= i_wb_dat[amt_pkg::CC_LTB_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // trigger source
  amt_trig_cmp u_trig (
    .i_clk       (i_clk),
    .i_rstn      (i_rstn),
    .i_local_tb  (local_tb_en),
    .i_timebase  (i_timebase),
    .i_cmp_value (trigger_compare_value),
    .o_trig      (trig_pulse)
  );

  // conversion start, mode latched at start for the whole conversion
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      busy          <= 1'b0;
      o_conv_start  <= 1'b0;
      o_conv_ch     <= '0;
      o_conv_channel_pair_input_mode   <= 1'b0;
      o_conv_signed <= 1'b0;
    end else begin
      o_conv_start <= start_req;
      if (start_req) begin
        busy          <= 1'b1;
        o_conv_ch     <= next_ch;
        o_conv_channel_pair_input_mode   <= start_pair[1];
        o_conv_signed <= start_pair[0];
      end else if (i_conv_done) begin
        busy <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  AST_CHANNEL_PAIR_INPUT_MODE_LATCH: assert property (@(posedge i_clk) disable iff (!i_rstn)
    start_req |=> o_conv_channel_pair_input_mode == $past(all_modes[{next_ch, 1'b0} + 5'h01]))
    else $error("input mode not taken at start");
  AST_SIGN_LATCH: assert property (@(posedge i_clk) disable iff (!i_rstn)
    start_req |=> o_conv_signed == $past(start_pair[0]))
    else $error("data format not taken at start");
  AST_LOW_WRITE: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (wr && hit_low && i_wb_sel[1:0] == 2'h3) |=> mode_low == $past(i_wb_dat[15:0]))
    else $error("low mode write lost");
  AST_HIGH_WRITE: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (wr && hit_high && i_wb_sel[1:0] == 2'h3) |=> mode_high == $past(i_wb_dat[15:0]))
    else $error("high mode write lost");
  AST_TRIG_START: assert property (@(posedge i_clk) disable iff (!i_rstn)
    ($rose(local_tb_en && i_timebase == trigger_compare_value) ##1 !busy) |=> o_conv_start)
    else $error("compare match did not start");
  AST_TRIG_ZERO: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (o_wb_ack && $past(hit_trig)) |-> o_wb_dat[2:0] == 3'h0)
    else $error("trigger low bits not zero");
  AST_HOLD_MODE: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (busy && !start_req) |=> $stable(o_conv_channel_pair_input_mode) && $stable(o_conv_signed))
    else $error("mode changed during conversion");
  AST_ACK_ONE: assert property (@(posedge i_clk) disable iff (!i_rstn)
    o_wb_ack |=> !o_wb_ack)
    else $error("ack longer than one cycle");

  // bus answer checks
  AST_ACK_NEXT: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (i_wb_cyc && i_wb_stb && !o_wb_ack) |=> o_wb_ack)
    else $error("request not answered in one cycle");
  AST_DAT_IDLE: assert property (@(posedge i_clk) disable iff (!i_rstn)
    !o_wb_ack |-> o_wb_dat == 32'h0000_0000)
    else $error("read data outside ack cycle");
  AST_DAT_UPPER: assert property (@(posedge i_clk) disable iff (!i_rstn)
    o_wb_ack |-> o_wb_dat[31:16] == 16'h0000)
    else $error("upper read lanes not zero");

  // register read and write checks
  AST_LOW_READ: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (req && !i_wb_we && hit_low) |=> o_wb_dat[15:0] == $past(mode_low))
    else $error("low mode read wrong");
  AST_HIGH_READ: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (req && !i_wb_we && hit_high) |=> o_wb_dat[15:0] == $past(mode_high))
    else $error("high mode read wrong");
  AST_TRIG_WRITE: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (wr && hit_trig && i_wb_sel[1:0] == 2'h3) |=> trigger_compare_value == $past(i_wb_dat[15:3]))
    else $error("compare value write lost");

  // trigger and conversion checks
  AST_LTB_OFF: assert property (@(posedge i_clk) disable iff (!i_rstn)
    !local_tb_en |=> !trig_pulse)
    else $error("trigger without local time base");
  AST_BUSY_REFUSE: assert property (@(posedge i_clk) disable iff (!i_rstn)
    busy |=> !o_conv_start)
    else $error("start taken while busy");
  AST_START_PULSE: assert property (@(posedge i_clk) disable iff (!i_rstn)
    o_conv_start |=> !o_conv_start)
    else $error("start longer than one cycle");
  AST_CH_LATCH: assert property (@(posedge i_clk) disable iff (!i_rstn)
    start_req |=> o_conv_ch == $past(next_ch))
    else $error("channel not taken at start");
  AST_CH_HOLD: assert property (@(posedge i_clk) disable iff (!i_rstn)
    !start_req |=> $stable(o_conv_ch))
    else $error("channel changed without start");
  AST_CTRL_BUSY: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (o_wb_ack && $past(hit_ctrl)) |-> o_wb_dat[8] == $past(busy))
    else $error("busy read back wrong");
endmodule : amt_top

// ==== verilog/amt_pkg.sv ====
// Purpose: constants for the converter input-mode and trigger-compare block
// Assumes: classic Wishbone, 32-bit data, registers 16 bits wide in the low lanes
// Notes:   byte offsets are word aligned
package amt_pkg;
  localparam logic [3:0]  OFS_TRIG       = 4'h0;   // trigger compare
  localparam logic [3:0]  OFS_MODE_LOW   = 4'h4;   // channels 0..7
  localparam logic [3:0]  OFS_MODE_HIGH  = 4'h8;   // channels 8..15
  localparam logic [3:0]  OFS_CONV_CTRL  = 4'hC;   // start request and status
  localparam logic [15:0] RST_TRIG       = 16'h0000;
  localparam logic [15:0] RST_MODE       = 16'h0000;
  localparam int          TRIG_LSB       = 3;
  localparam int          TRIG_W         = 13;
  localparam int          NUM_CH         = 16;
  localparam int          CH_W           = 4;
  localparam logic [2:0]  TRIG_LOW_MASK  = 3'h0;  // unimplemented bits
  // conversion control register fields
  localparam int          CC_CH_LSB      = 0;      // channel select, bits 3:0
  localparam int          CC_START_BIT   = 4;      // write 1 to start
  localparam int          CC_LTB_BIT     = 5;      // local time base enable
  localparam int          CC_BUSY_BIT    = 8;      // read only
  localparam int          CC_CHANNEL_PAIR_INPUT_MODE_BIT    = 9;      // read only, current mode of selected channel
  localparam int          CC_SIGN_BIT    = 10;     // read only, current format of selected channel
endpackage : amt_pkg

// ==== verilog/amt_trig_cmp.sv ====
// Purpose: compare the local time base against the trigger compare value
// Assumes: time base and compare value are on the same clock
// Notes:   the trigger is a one-cycle pulse on the rising edge of a match
`timescale 1ns/100ps
module amt_trig_cmp (
  // clock and reset
  input  wire logic                         i_clk,
  input  wire logic                         i_rstn,
  // compare inputs
  input  wire logic                         i_local_tb,
  input  wire logic [amt_pkg::TRIG_W-1:0]   i_timebase,
  input  wire logic [amt_pkg::TRIG_W-1:0]   i_cmp_value,
  // trigger pulse
  output logic                              o_trig
);
  logic match_d;
  wire  match = i_local_tb && (i_timebase == i_cmp_value);

  // pulse on the first cycle of a match only
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      match_d <= 1'b0;
      o_trig  <= 1'b0;
    end else begin
      match_d <= match;
      o_trig  <= match && !match_d;
    end
  end
endmodule : amt_trig_cmp

// ==== verification/tb_top.sv ====
// Purpose: self-checking bench for the channel mode and trigger compare block
// Assumes: ack one cycle after a request, start pulse with the ack
// Notes:   no random stimulus, every wait bounded
`timescale 1ns/100ps
module tb_top;
  logic        i_clk = 1'b0;
  logic        i_rstn = 1'b0;
  logic        cyc = 1'b0;
  logic        we = 1'b0;
  logic        done = 1'b0;
  logic [3:0]  adr = 4'h0;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] rd_bus;
  logic [12:0] tbase = 13'h0;
  logic        ack, st, dif, sgn, s_st, s_dif, s_sgn;
  logic [3:0]  ch, s_ch;
  logic [15:0] m [2];
  int          bad_count = 0;
  int          compares = 0;

  amt_top dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_wb_cyc(cyc), .i_wb_stb(cyc), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rd_bus), .o_wb_ack(ack),
    .i_timebase(tbase), .o_conv_start(st), .o_conv_ch(ch), .o_conv_channel_pair_input_mode(dif),
    .o_conv_signed(sgn), .i_conv_done(done));

  // 50 MHz clock
  always #10 i_clk = ~i_clk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    if (bad_count == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : print_verdict

  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : check

  // one classic cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [3:0] a, input logic [3:0] s, input logic [31:0] d);
    int k;
    @(posedge i_clk);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= d;
    for (k = 0; k < 20; k++) begin
      @(posedge i_clk);
      if (ack === 1'b1) break;
    end
    if (ack !== 1'b1) begin
      check("ack", 32'h1, 32'h0);
      print_verdict();
    end else begin
      rdat = rd_bus;
      s_st = st;
      s_ch = ch;
      s_dif = dif;
      s_sgn = sgn;
      cyc <= 1'b0;
      we <= 1'b0;
    end
  endtask : wb

  // converter finishes: one done pulse
  task automatic finish_conv;
    @(posedge i_clk);
    done <= 1'b1;
    @(posedge i_clk);
    done <= 1'b0;
  endtask : finish_conv

  ////////////////////////////////////////////////////////////////////////////
  // reset values and the compare register's low bits and lanes
  task automatic t_regs;
    wb(1'b0, amt_pkg::OFS_TRIG, 4'h3, 32'h0);
    check("trig rst", 32'h0, rdat);
    wb(1'b0, amt_pkg::OFS_MODE_LOW, 4'h3, 32'h0);
    check("low rst", 32'h0, rdat);
    wb(1'b0, amt_pkg::OFS_MODE_HIGH, 4'h3, 32'h0);
    check("high rst", 32'h0, rdat);
    wb(1'b1, amt_pkg::OFS_TRIG, 4'h3, 32'hFFFF);
    wb(1'b0, amt_pkg::OFS_TRIG, 4'h3, 32'h0);
    check("trig all", 32'hFFF8, rdat);
    wb(1'b1, amt_pkg::OFS_TRIG, 4'h3, 32'h0);
    wb(1'b1, amt_pkg::OFS_TRIG, 4'h2, 32'hFFFF);
    wb(1'b0, amt_pkg::OFS_TRIG, 4'h3, 32'h0);
    check("trig lane", 32'hFF00, rdat);
  endtask : t_regs

  // every channel started by software with each mode pattern
  task automatic t_conv(input logic [15:0] lo, input logic [15:0] hi);
    int c;
    m[0] = lo;
    m[1] = hi;
    wb(1'b1, amt_pkg::OFS_MODE_LOW, 4'h3, {16'h0, lo});
    wb(1'b1, amt_pkg::OFS_MODE_HIGH, 4'h3, {16'h0, hi});
    wb(1'b0, amt_pkg::OFS_MODE_LOW, 4'h3, 32'h0);
    check("low back", {16'h0, lo}, rdat);
    wb(1'b0, amt_pkg::OFS_MODE_HIGH, 4'h3, 32'h0);
    check("high back", {16'h0, hi}, rdat);
    for (c = 0; c < 16; c++) begin
      wb(1'b1, amt_pkg::OFS_CONV_CTRL, 4'h3, 32'h10 | 32'(c));
      check("start", 32'h1, {31'h0, s_st});
      check("ch", 32'(c), {28'h0, s_ch});
      check("channel_pair_input_mode", {31'h0, m[c/8][2*(c%8)+1]}, {31'h0, s_dif});
      check("signed", {31'h0, m[c/8][2*(c%8)]}, {31'h0, s_sgn});
      if (c == 0) begin
        wb(1'b1, amt_pkg::OFS_CONV_CTRL, 4'h3, 32'h11);
        check("busy start", 32'h0, {31'h0, s_st});
        wb(1'b0, amt_pkg::OFS_CONV_CTRL, 4'h3, 32'h0);
        check("busy", 32'h1, (rdat >> 8) & 32'h1);
        check("ctrl read", {21'h0, m[0][2], m[0][3], 1'b1, 4'h0, 4'h1}, rdat);
        wb(1'b1, amt_pkg::OFS_MODE_LOW, 4'h3, {16'h0, ~lo});
        wb(1'b0, amt_pkg::OFS_CONV_CTRL, 4'h3, 32'h0);
        check("held mode", {30'h0, m[0][1], m[0][0]}, {30'h0, s_dif, s_sgn});
        check("sel mode new", {30'h0, ~m[0][2], ~m[0][3]}, (rdat >> 9) & 32'h3);
        wb(1'b1, amt_pkg::OFS_MODE_LOW, 4'h3, {16'h0, lo});
      end
      finish_conv();
    end
  endtask : t_conv

  // local time base match starts a conversion once
  task automatic t_ltb;
    int k;
    int first;
    int hits;
    first = -1;
    hits = 0;
    wb(1'b1, amt_pkg::OFS_TRIG, 4'h3, {16'h0, 13'h064, 3'h0});
    wb(1'b1, amt_pkg::OFS_CONV_CTRL, 4'h3, 32'h25);
    for (k = 0; k < 14; k++) begin
      @(posedge i_clk);
      if (st === 1'b1 && first < 0) first = k;
      if (st === 1'b1) hits++;
      tbase <= (k < 5) ? 13'(95 + k) : 13'h064;
    end
    check("match edge", 32'h8, 32'(first));
    check("match pulses", 32'h1, 32'(hits));
    check("match ch", 32'h5, {28'h0, ch});
    finish_conv();
    wb(1'b1, amt_pkg::OFS_CONV_CTRL, 4'h3, 32'h0);
  endtask : t_ltb

  ////////////////////////////////////////////////////////////////////////////
  // reset, then the scenarios in turn
  initial begin
    repeat (4) @(posedge i_clk);
    i_rstn <= 1'b1;
    t_regs();
    t_conv(16'h1B1B, 16'hE4E4);
    t_conv(16'hE4E4, 16'h1B1B);
    t_ltb();
    print_verdict();
  end
endmodule : tb_top
